// *** fault_record_trigger_ctrl.sv ***
`timescale 1ns/1ns
module fault_record_trigger_ctrl
    import fault_record_pkg::*;
#(
    parameter int CLOCK_FREQ_HZ = CLOCK_HZ,
    parameter int SAMPLE_WIDTH = 16,
    parameter int PRE_DEPTH = 256,
    parameter int FIFO_DEPTH = 8,
    parameter int RELAY_MIN_ON_CYCLES = (CLOCK_FREQ_HZ / 1000) * RELAY_MIN_ON_MS,
    parameter int TRANS_MIN_CYCLES = (CLOCK_FREQ_HZ / 1000) * TRANSIENT_MIN_POST_MS,
    parameter int TRANS_MAX_CYCLES = (CLOCK_FREQ_HZ / 1000) * TRANSIENT_MAX_MS,
    parameter int DIST_MIN_CYCLES = (CLOCK_FREQ_HZ / 1000) * DISTURB_MIN_POST_MS,
    parameter int DIST_MAX_CYCLES = (CLOCK_FREQ_HZ / 1000) * DISTURB_MAX_MS,
    parameter int SAFETY_CYCLES = (CLOCK_FREQ_HZ / 1000) * SAFETY_WINDOW_MS,
    parameter int DIST_SAMPLE_CYCLES = CLOCK_FREQ_HZ / (MAINS_HZ * DISTURB_PER_CYCLE)
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [3:0] address,
    input wire logic [15:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [15:0] readData,
    input wire logic supplyPresent,
    input wire logic sampleTick,
    input wire logic [SAMPLE_WIDTH-1:0] sampleData,
    input wire logic externalTrigger,
    output logic [1:0] samplePhase,
    output logic recordValid,
    input wire logic recordReady,
    output logic [SAMPLE_WIDTH-1:0] recordData,
    output logic recordPost,
    output logic disturbanceStrobe,
    output logic relayPower,
    output logic relayArmed,
    output logic relayTriggered,
    output logic relayAttention
);
    localparam int PW = $clog2(PRE_DEPTH);
    initial begin
        if (PRE_DEPTH < 2 || (1 << PW) != PRE_DEPTH) $error("PRE_DEPTH must be a power of two");
        if (TRANS_MIN_CYCLES > TRANS_MAX_CYCLES || DIST_MIN_CYCLES > DIST_MAX_CYCLES)
            $error("Minimum post-fault longer than maximum record");
        if (RELAY_MIN_ON_CYCLES < 1 || SAFETY_CYCLES < 1 || DIST_SAMPLE_CYCLES < 1)
            $error("Timing counts must be at least one cycle");
    end

    typedef enum logic [1:0] {IDLE, CAPTURE, DRAIN} rec_type;

    // Software-visible registers
    logic [3:0] control;
    logic [1:0] rate;
    logic [15:0] limitLow;
    logic [15:0] limitHigh;
    logic [15:0] recordCount;

    wire logic armed = control[CTRL_ARM_BIT];
    wire logic selfTestFail = control[CTRL_SELFTEST_FAIL_BIT];
    wire logic crossEnable = control[CTRL_CROSS_ENABLE_BIT];
    wire logic writeHit = writeStrobe;
    wire logic manualPulse = writeHit && address == ADDR_CONTROL
        && writeData[CTRL_MANUAL_TRIGGER_BIT];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            control <= CONTROL_RESET;
            rate <= RATE_RESET;
            limitLow <= LIMIT_LOW_RESET;
            limitHigh <= LIMIT_HIGH_RESET;
        end else if (writeHit) begin
            if (address == ADDR_CONTROL) control <= {writeData[3], 1'b0, writeData[1:0]};
            if (address == ADDR_RATE && writeData[1:0] != 2'h3) rate <= writeData[1:0];
            if (address == ADDR_LIMIT_LOW) limitLow <= writeData;
            if (address == ADDR_LIMIT_HIGH) limitHigh <= writeData;
        end
    end

    // Sample decimation: front end ticks at 256 per cycle, we keep 1 of 1, 2 or 4
    logic [1:0] tickCount;
    wire logic [1:0] keepMask = rate == RATE_SPC64 ? 2'h3 : rate == RATE_SPC128 ? 2'h1 : 2'h0;
    wire logic keepSample = sampleTick && ((tickCount & keepMask) == 2'h0) && armed;
    assign samplePhase = tickCount;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) tickCount <= 2'h0;
        else if (sampleTick) tickCount <= tickCount + 2'h1;
    end

    // Level comparison
    wire logic abnormal = sampleData < limitLow || sampleData > limitHigh;
    logic levelTrigger;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) levelTrigger <= 1'b0;
        else if (!armed) levelTrigger <= 1'b0;
        else if (keepSample) levelTrigger <= abnormal;
    end

    // Disturbance recorder state, declared here for the cross-trigger
    rec_type distState;
    logic [31:0] distCount;
    wire logic distActive = distState == CAPTURE;
    wire logic anyTrigger = armed && (levelTrigger || externalTrigger || manualPulse);
    // Cross starts fire only on the other recorder's first capture cycle;
    // a level cross term would let the pair keep each other alive forever
    wire logic distStarted = armed && crossEnable && distActive && distCount == '0;
    wire logic transTrigger = anyTrigger || distStarted;

    // Transient recorder
    rec_type transState;
    logic [31:0] transCount;
    logic [31:0] transQuiet;
    logic transLong;
    wire logic transMinDone = transCount >= 32'(TRANS_MIN_CYCLES);
    wire logic transMaxDone = transCount >= 32'(TRANS_MAX_CYCLES);
    wire logic transQuietDone = transQuiet >= 32'(SAFETY_CYCLES);
    wire logic transEnd = transMaxDone || (transMinDone && transQuietDone);

    // Pre-fault circular buffer
    logic [SAMPLE_WIDTH-1:0] preMem [PRE_DEPTH];
    logic [PW-1:0] preWrite;
    logic [PW-1:0] preRead;
    logic [PW:0] preFill;
    logic [PW:0] drainLeft;
    wire logic fifoInReady;
    wire logic preWriteEn = keepSample && transState == IDLE;

    always_ff @(posedge clock) begin
        if (preWriteEn) preMem[preWrite] <= sampleData;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            preWrite <= '0;
            preFill <= '0;
        end else if (!armed) begin
            preFill <= '0;
        end else if (preWriteEn) begin
            preWrite <= preWrite + 1'b1;
            if (preFill != (PW + 1)'(PRE_DEPTH)) preFill <= preFill + 1'b1;
        end else if (transState == DRAIN && drainLeft == '0) begin
            preFill <= '0;
        end
    end

    // Record stream: post-fault samples first, then pre-fault history drained
    wire logic postPush = transState == CAPTURE && keepSample;
    wire logic drainPush = transState == DRAIN && drainLeft != '0;
    wire logic fifoInValid = postPush || drainPush;
    wire logic [SAMPLE_WIDTH:0] fifoInData = postPush ? {1'b1, sampleData}
        : {1'b0, preMem[preRead]};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            transState <= IDLE;
            transCount <= '0;
            transQuiet <= '0;
            transLong <= 1'b0;
            preRead <= '0;
            drainLeft <= '0;
            recordCount <= '0;
        end else begin
            unique case (transState)
                IDLE: begin
                    if (transTrigger) begin
                        transState <= CAPTURE;
                        transCount <= '0;
                        transQuiet <= '0;
                        transLong <= 1'b0;
                        preRead <= preWrite - preFill[PW-1:0];
                        drainLeft <= preFill;
                    end
                end
                CAPTURE: begin
                    transCount <= transCount + 1'b1;
                    transQuiet <= anyTrigger ? '0 : transQuiet + 1'b1;
                    if (!armed) begin
                        transState <= IDLE;
                    end else if (transEnd) begin
                        transLong <= transMaxDone && anyTrigger;
                        transState <= DRAIN;
                        recordCount <= recordCount + 1'b1;
                    end
                end
                DRAIN: begin
                    if (drainPush && fifoInReady) begin
                        preRead <= preRead + 1'b1;
                        drainLeft <= drainLeft - 1'b1;
                    end
                    if (drainLeft == '0) transState <= IDLE;
                end
                default: transState <= IDLE;
            endcase
        end
    end

    sample_fifo #(
        .WIDTH(SAMPLE_WIDTH + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rstn(rstn),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(recordValid),
        .outReady(recordReady),
        .outData({recordPost, recordData})
    );

    // Disturbance recorder: twice-per-cycle phasor strobe while capturing
    logic [31:0] distQuiet;
    logic [31:0] distTick;
    wire logic distTrigger = anyTrigger || (armed && crossEnable && transState == CAPTURE
        && transCount == '0);
    wire logic distEnd = distCount >= 32'(DIST_MAX_CYCLES)
        || (distCount >= 32'(DIST_MIN_CYCLES) && distQuiet >= 32'(SAFETY_CYCLES));
    assign disturbanceStrobe = distActive && distTick == '0;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            distState <= IDLE;
            distCount <= '0;
            distQuiet <= '0;
            distTick <= '0;
        end else begin
            distTick <= (distTick == 32'(DIST_SAMPLE_CYCLES - 1)) ? '0 : distTick + 1'b1;
            unique case (distState)
                IDLE: begin
                    distCount <= '0;
                    distQuiet <= '0;
                    if (distTrigger) distState <= CAPTURE;
                end
                CAPTURE: begin
                    distCount <= distCount + 1'b1;
                    distQuiet <= anyTrigger ? '0 : distQuiet + 1'b1;
                    if (!armed || distEnd) distState <= IDLE;
                end
                default: distState <= IDLE;
            endcase
        end
    end

    // Triggered relay with minimum on-time
    logic [31:0] relayHold;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) relayHold <= '0;
        else if (anyTrigger) relayHold <= 32'(RELAY_MIN_ON_CYCLES);
        else if (relayHold != '0) relayHold <= relayHold - 1'b1;
    end

    assign relayPower = supplyPresent;
    assign relayArmed = armed;
    assign relayTriggered = anyTrigger || relayHold != '0;
    assign relayAttention = selfTestFail;

    // Read port, data one cycle after the strobe
    wire logic [15:0] statusWord = {10'h000, transLong, distActive,
        transState == DRAIN, transState == CAPTURE, levelTrigger, armed};
    wire logic [15:0] readMux =
        address == ADDR_CONTROL ? {12'h000, control} :
        address == ADDR_RATE ? {14'h0000, rate} :
        address == ADDR_LIMIT_LOW ? limitLow :
        address == ADDR_LIMIT_HIGH ? limitHigh :
        address == ADDR_STATUS ? statusWord :
        address == ADDR_WRITE_POINTER ? 16'(preWrite) :
        address == ADDR_RECORD_COUNT ? recordCount : 16'h0000;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) readData <= 16'h0000;
        else readData <= readStrobe ? readMux : 16'h0000;
    end

    // Checks
    property p_relay_min_on;
        @(posedge clock) disable iff (!rstn)
        $rose(relayTriggered) |-> relayTriggered [*8];
    endproperty
    a_relay_min_on: assert property (p_relay_min_on) else $error("Relay on too briefly");

    property p_attention;
        @(posedge clock) disable iff (!rstn)
        relayAttention == control[CTRL_SELFTEST_FAIL_BIT];
    endproperty
    a_attention: assert property (p_attention) else $error("Attention relay mismatch");

    property p_power;
        @(posedge clock) disable iff (!rstn) relayPower == supplyPresent;
    endproperty
    a_power: assert property (p_power) else $error("Power relay mismatch");

    property p_disarm_quiet;
        @(posedge clock) disable iff (!rstn)
        !armed |-> ##1 (transState != CAPTURE && !levelTrigger);
    endproperty
    a_disarm_quiet: assert property (p_disarm_quiet) else $error("Capture while disarmed");

    property p_trigger_starts;
        @(posedge clock) disable iff (!rstn)
        (transState == IDLE && anyTrigger) |=> transState == CAPTURE;
    endproperty
    a_trigger_starts: assert property (p_trigger_starts) else $error("Trigger missed");

    property p_max_length;
        @(posedge clock) disable iff (!rstn)
        transState == CAPTURE |-> transCount <= 32'(TRANS_MAX_CYCLES);
    endproperty
    a_max_length: assert property (p_max_length) else $error("Record over maximum");

    property p_min_post;
        @(posedge clock) disable iff (!rstn)
        (transState == CAPTURE && $past(transState) == CAPTURE) ##1 transState == DRAIN
            |-> $past(transCount, 1) >= 32'(TRANS_MIN_CYCLES);
    endproperty
    a_min_post: assert property (p_min_post) else $error("Ended before minimum");

    property p_cross;
        @(posedge clock) disable iff (!rstn)
        (crossEnable && armed && transState == CAPTURE && transCount == '0)
            |-> ##[0:1] distState == CAPTURE;
    endproperty
    a_cross: assert property (p_cross) else $error("Cross trigger missed");

    property p_rate_legal;
        @(posedge clock) disable iff (!rstn) rate != 2'h3;
    endproperty
    a_rate_legal: assert property (p_rate_legal) else $error("Illegal rate code");

    property p_relay_reload;
        @(posedge clock) disable iff (!rstn)
        anyTrigger |=> relayHold == 32'(RELAY_MIN_ON_CYCLES);
    endproperty
    a_relay_reload: assert property (p_relay_reload) else $error("Relay hold not reloaded");

    property p_dist_max;
        @(posedge clock) disable iff (!rstn)
        distState == CAPTURE |-> distCount <= 32'(DIST_MAX_CYCLES);
    endproperty
    a_dist_max: assert property (p_dist_max) else $error("Disturbance over maximum");

    property p_post_push;
        @(posedge clock) disable iff (!rstn)
        (postPush && fifoInReady) |=> recordValid;
    endproperty
    a_post_push: assert property (p_post_push) else $error("Post sample lost");

    property p_drain_order;
        @(posedge clock) disable iff (!rstn)
        (drainPush && fifoInReady) |=> preRead == $past(preRead) + 1'b1;
    endproperty
    a_drain_order: assert property (p_drain_order) else $error("History out of order");

    property p_pre_wrap;
        @(posedge clock) disable iff (!rstn)
        (preWriteEn && preWrite == '1) |=> preWrite == '0;
    endproperty
    a_pre_wrap: assert property (p_pre_wrap) else $error("Circular buffer did not wrap");

    property p_strobe_gap;
        @(posedge clock) disable iff (!rstn)
        (disturbanceStrobe && DIST_SAMPLE_CYCLES > 1) |=> !disturbanceStrobe;
    endproperty
    a_strobe_gap: assert property (p_strobe_gap) else $error("Strobe too frequent");

    property p_drain_end;
        @(posedge clock) disable iff (!rstn)
        (transState == DRAIN && drainLeft == '0) |=> transState == IDLE;
    endproperty
    a_drain_end: assert property (p_drain_end) else $error("Record did not close");
endmodule : fault_record_trigger_ctrl

// *** fault_record_pkg.sv ***
package fault_record_pkg;
    // Register indices on the plain port (word addresses)
    localparam logic [3:0] ADDR_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_RATE = 4'h1;
    localparam logic [3:0] ADDR_LIMIT_LOW = 4'h2;
    localparam logic [3:0] ADDR_LIMIT_HIGH = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_WRITE_POINTER = 4'h5;
    localparam logic [3:0] ADDR_RECORD_COUNT = 4'h6;
    // Control fields
    localparam int CTRL_ARM_BIT = 0;
    localparam int CTRL_SELFTEST_FAIL_BIT = 1;
    localparam int CTRL_MANUAL_TRIGGER_BIT = 2;
    localparam int CTRL_CROSS_ENABLE_BIT = 3;
    localparam logic [3:0] CONTROL_RESET = 4'h8;
    // Rate field codes for samples_per_power_cycle
    localparam logic [1:0] RATE_SPC64 = 2'h0;
    localparam logic [1:0] RATE_SPC128 = 2'h1;
    localparam logic [1:0] RATE_SPC256 = 2'h2;
    localparam logic [1:0] RATE_RESET = 2'h2;
    localparam logic [15:0] LIMIT_LOW_RESET = 16'h1000;
    localparam logic [15:0] LIMIT_HIGH_RESET = 16'hF000;
    // Timing
    localparam int CLOCK_HZ = 10000000;
    localparam int RELAY_MIN_ON_MS = 500;
    localparam int TRANSIENT_MIN_POST_MS = 100;
    localparam int TRANSIENT_MAX_MS = 1000;
    localparam int DISTURB_MIN_POST_MS = 2000;
    localparam int DISTURB_MAX_MS = 180000;
    localparam int SAFETY_WINDOW_MS = 50;
    localparam int MAINS_HZ = 50;
    localparam int DISTURB_PER_CYCLE = 2;
endpackage : fault_record_pkg

// *** sample_fifo.sv ***
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    wire logic doWrite = inValid && inReady;
    wire logic doRead = outValid && outReady;
    assign inReady = (wrPtr - rdPtr) != (AW + 1)'(DEPTH);
    assign outValid = wrPtr != rdPtr;
    assign outData = mem[rdPtr[AW-1:0]];
    always_ff @(posedge clock) begin
        if (doWrite) mem[wrPtr[AW-1:0]] <= inData;
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wrPtr <= '0;
            rdPtr <= '0;
        end else begin
            if (doWrite) wrPtr <= wrPtr + 1'b1;
            if (doRead) rdPtr <= rdPtr + 1'b1;
        end
    end
endmodule : sample_fifo

// *** front_end_model.sv ***
`timescale 1ns/1ns
module front_end_model #(
    parameter int TICK_DIV = 4
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic fault,
    input wire logic stall,
    output logic sampleTick,
    output logic [15:0] sampleData,
    output logic recordReady
);
    int phase;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase <= 0;
            sampleTick <= 1'b0;
            sampleData <= 16'h8000;
            recordReady <= 1'b0;
        end else begin
            phase <= (phase == TICK_DIV - 1) ? 0 : phase + 1;
            sampleTick <= (phase == 0);
            // Outside a fault the value moves every cycle so a stale sample is never taken for a fresh one
            sampleData <= fault ? 16'hF800 : 16'h7000 + 16'($urandom % 32'h2000);
            // Random stalls keep the record FIFO under backpressure
            recordReady <= stall ? ($urandom % 4 == 0) : 1'b1;
        end
    end
endmodule : front_end_model

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
    import fault_record_pkg::*;
    localparam int RELAY_ON = 20;
    logic clock, rstn, writeStrobe, readStrobe, supplyPresent, externalTrigger;
    logic fault, stall, sampleTick, recordValid, recordReady, recordPost;
    logic disturbanceStrobe, relayPower, relayArmed, relayTriggered, relayAttention, seen;
    logic [3:0] address;
    logic [15:0] writeData, readData, sampleData, recordData, v, r, firstPost, lastPre;
    logic [1:0] samplePhase, rate;
    int n_mismatch, n_tests, nPost, nPre, nStrobe;

    fault_record_trigger_ctrl #(.PRE_DEPTH(16), .RELAY_MIN_ON_CYCLES(RELAY_ON),
        .TRANS_MIN_CYCLES(30), .TRANS_MAX_CYCLES(100), .DIST_MIN_CYCLES(200),
        .DIST_MAX_CYCLES(1000), .SAFETY_CYCLES(10), .DIST_SAMPLE_CYCLES(16)
    ) fault_record_trigger_ctrl_inst (
        .clock(clock), .rstn(rstn), .address(address), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
        .supplyPresent(supplyPresent), .sampleTick(sampleTick), .sampleData(sampleData),
        .externalTrigger(externalTrigger), .samplePhase(samplePhase),
        .recordValid(recordValid), .recordReady(recordReady), .recordData(recordData),
        .recordPost(recordPost), .disturbanceStrobe(disturbanceStrobe),
        .relayPower(relayPower), .relayArmed(relayArmed),
        .relayTriggered(relayTriggered), .relayAttention(relayAttention)
    );

    front_end_model front_end_model_inst (
        .clock(clock), .rstn(rstn), .fault(fault), .stall(stall),
        .sampleTick(sampleTick), .sampleData(sampleData), .recordReady(recordReady)
    );

    function automatic logic [1:0] exp_rate(input logic [1:0] old, input logic [1:0] code);
        // Code 3 is no rate at all, so the old one must survive
        return (code == 2'h3) ? old : code;
    endfunction : exp_rate

    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1 d = readData;
    endtask : rd

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cycles

    task automatic conclude();
        $display("Mismatches %0d in %0d comparisons", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        #(20000 * 100);
        n_mismatch++;
        conclude();
    end

    initial begin
        {rstn, writeStrobe, readStrobe, externalTrigger, fault, stall} = 6'h00;
        supplyPresent = 1'b1;
        address = 4'h0;
        writeData = 16'h0000;
        void'($urandom(19));
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        rd(ADDR_CONTROL, v); check("control reset", v, 16'(CONTROL_RESET));
        rd(ADDR_LIMIT_LOW, v); check("low limit reset", v, LIMIT_LOW_RESET);
        rd(ADDR_LIMIT_HIGH, v); check("high limit reset", v, LIMIT_HIGH_RESET);
        rate = RATE_RESET;
        rd(ADDR_RATE, v); check("rate reset", v, 16'(rate));
        for (int i = 0; i < 6; i++) begin
            r = (i < 4) ? 16'(i) : 16'($urandom % 4);
            wr(ADDR_RATE, r);
            check("read data idle", readData, 16'h0000);
            rate = exp_rate(rate, r[1:0]);
            rd(ADDR_RATE, v); check("rate", v, 16'(rate));
        end
        wr(ADDR_RATE, 16'(RATE_SPC256));
        r = 16'($urandom);
        wr(ADDR_LIMIT_LOW, r);
        rd(ADDR_LIMIT_LOW, v); check("low limit", v, r);
        wr(ADDR_LIMIT_LOW, LIMIT_LOW_RESET);
        wr(4'h7, r);
        rd(4'h7, v); check("unmapped", v, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            supplyPresent <= 1'($urandom);
            cycles(2);
            check("power relay", 16'(relayPower), 16'(supplyPresent));
        end
        supplyPresent <= 1'b1;
        // Disarmed: neither a level fault nor the external input may do anything
        fault <= 1'b1;
        externalTrigger <= 1'b1;
        seen = 1'b0;
        repeat (60) begin
            fault <= 1'($urandom);
            externalTrigger <= 1'($urandom);
            cycles(1);
            seen = seen | relayTriggered | recordValid | relayArmed;
        end
        check("disarmed activity", 16'(seen), 16'h0000);
        fault <= 1'b0;
        externalTrigger <= 1'b0;
        wr(ADDR_CONTROL, 16'h000A);
        cycles(2);
        check("attention on", 16'(relayAttention), 16'h0001);
        wr(ADDR_CONTROL, 16'h0008);
        cycles(2);
        check("attention off", 16'(relayAttention), 16'h0000);
        // Cross trigger off so a disturbance start cannot start a transient record; the relay hold ignores it
        wr(ADDR_CONTROL, 16'h0001);
        cycles(2);
        check("armed relay", 16'(relayArmed), 16'h0001);
        rd(ADDR_STATUS, v); check("status armed", v, 16'h0001);
        seen = 1'b0;
        r = 16'(samplePhase);
        nStrobe = 0;
        repeat (300) begin
            nStrobe += int'(sampleTick);
            cycles(1);
            seen = seen | relayTriggered;
        end
        check("quiet inputs", 16'(seen), 16'h0000);
        check("sample phase", 16'(samplePhase), 16'((int'(r) + nStrobe) % 4));
        externalTrigger <= 1'b1;
        cycles(3);
        externalTrigger <= 1'b0;
        cycles(2);
        check("triggered relay", 16'(relayTriggered), 16'h0001);
        cycles(RELAY_ON - 4);
        check("relay min on", 16'(relayTriggered), 16'h0001);
        cycles(10);
        check("relay released", 16'(relayTriggered), 16'h0000);
        cycles(1500);
        wr(ADDR_CONTROL, 16'h0005);
        cycles(2);
        check("manual trigger", 16'(relayTriggered), 16'h0001);
        rd(ADDR_CONTROL, v); check("manual bit clears", v, 16'h0001);
        cycles(300);
        wr(ADDR_CONTROL, 16'h0009);
        stall <= 1'b1;
        fault <= 1'b1;
        cycles(40);
        check("level trigger", 16'(relayTriggered), 16'h0001);
        fault <= 1'b0;
        {nPost, nPre, nStrobe} = '0;
        repeat (3000) begin
            @(posedge clock);
            stall <= ($urandom % 8) != 0;
            if (recordValid && recordReady && recordPost && nPost == 0) firstPost = recordData;
            if (recordValid && recordReady && !recordPost) lastPre = recordData;
            nPost += int'(recordValid && recordReady && recordPost);
            nPre += int'(recordValid && recordReady && !recordPost);
            nStrobe += int'(disturbanceStrobe);
        end
        check("post samples", 16'(nPost > 0), 16'h0001);
        check("pre samples", 16'(nPre > 0), 16'h0001);
        check("disturbance run", 16'(nStrobe > 0), 16'h0001);
        check("disturbance bound", 16'(nStrobe <= 1000 / 16 + 1), 16'h0001);
        check("first post word", firstPost, 16'hF800);
        check("newest pre word", lastPre, 16'hF800);
        #1 check("drained", 16'(recordValid), 16'h0000);
        rd(ADDR_RECORD_COUNT, v); check("record count", v, 16'h0003);
        conclude();
    end
endmodule : tb
